// ---- design/bus_drive_stage.v ----
// output stage that registers the bus lines and their enables
`include "hold_arb_consts.vh"
`default_nettype none
module bus_drive_stage #(
    parameter DATA_W = 16,
    parameter CTRL_W = 8
) (
    input  wire              core_clk,    // core clock
    input  wire              rst_n,       // async reset, active low
    input  wire              drive,       // bus owned by the core
    input  wire [DATA_W-1:0] data_in,     // data from the core
    input  wire              data_wr,     // core wants data driven
    input  wire [CTRL_W-1:0] ctrl_in,     // control lines from core
    output reg  [DATA_W-1:0] data_out,    // data pin output
    output reg               data_oe,     // data pin enable
    output reg  [CTRL_W-1:0] ctrl_out,    // control pin output
    output reg               ctrl_oe      // control pin enable
);
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= {DATA_W{`HA_DATA_RST_BIT}};
            data_oe  <= `HA_OE_OFF;
            ctrl_out <= {CTRL_W{`HA_CTRL_IDLE_BIT}};
            ctrl_oe  <= `HA_OE_OFF;
        end else begin
            data_out <= data_in;
            data_oe  <= drive & data_wr;
            ctrl_out <= ctrl_in;
            ctrl_oe  <= drive;
        end
    end
endmodule // bus_drive_stage
`default_nettype wire

// ---- design/hold_arb_consts.vh ----
// constants of the local bus hold arbitration block
`ifndef HOLD_ARB_CONSTS_VH
`define HOLD_ARB_CONSTS_VH
`define HA_DATA_W        16
`define HA_CTRL_W        8
`define HA_CTRL_IDLE     8'hff
`define HA_REL_NS        10
`define HA_CLK_NS        10
`define HA_REL_CYC       ((`HA_REL_NS + `HA_CLK_NS - 1) / `HA_CLK_NS)
`define HA_ST_OWN        2'h0
`define HA_ST_FLOAT      2'h1
`define HA_ST_GRANT      2'h2
`define HA_ST_RESUME     2'h3
`define HA_RST_WAIT      4'h0
`define HA_RST_DRIVE     1'b1
`define HA_RST_IN_RESET  1'b1
`define HA_RST_GRANT     1'b0
`define HA_RST_LOCK_N    1'b1
`define HA_RST_LOCK_OE   1'b0
`define HA_RST_PULLUP    1'b1
`define HA_RST_CYC_GO    1'b0
`define HA_DATA_RST_BIT  1'b0
`define HA_CTRL_IDLE_BIT 1'b1
`define HA_OE_OFF        1'b0
`endif

// ---- design/local_bus_hold_arbitration.v ----
// hold request arbitration and bus release for the local bus
// Functional notes
// - grant output goes high once the core has given up the bus.
// - data bus and control outputs float while grant is high.
// - bus is released only at an instruction boundary outside locked sequences.
// - atomic-cycle output is low during a cycle that must not be interrupted.
// - while atomic output is low, requests are ignored and grant stays low.
// - in reset the atomic pin is weakly high; outside logic must not pull it low.
`include "hold_arb_consts.vh"
`default_nettype none
module local_bus_hold_arbitration #(
    parameter DATA_W = `HA_DATA_W,
    parameter CTRL_W = `HA_CTRL_W
) (
    input  wire              core_clk,      // core clock, 100 MHz
    input  wire              rst_n,         // async reset, active low
    input  wire              hold_req,      // external bus master request
    input  wire              instr_end,     // core at an instruction boundary
    input  wire              lock_seq,      // core inside a locked instruction sequence
    input  wire              core_cyc_req,  // core wants to start a bus cycle
    input  wire [DATA_W-1:0] core_data,     // core write data
    input  wire              core_data_wr,  // core drives data this cycle
    input  wire [CTRL_W-1:0] core_ctrl,     // core bus control lines
    output reg               hold_grant,    // bus handed to other master
    output reg               lock_out_n,    // atomic cycle, active low
    output reg               lock_oe,       // atomic pin enable
    output reg               lock_pullup,   // weak pull-up on atomic pin
    output reg               core_cyc_go,   // core may start its bus cycle
    output wire [DATA_W-1:0] bus_data_out,  // data pin output
    output wire              bus_data_oe,   // data pin enable
    output wire [CTRL_W-1:0] bus_ctrl_out,  // control pin output
    output wire              bus_ctrl_oe    // control pin enable
);
    localparam [1:0] ST_OWN    = `HA_ST_OWN;
    localparam [1:0] ST_FLOAT  = `HA_ST_FLOAT;
    localparam [1:0] ST_GRANT  = `HA_ST_GRANT;
    localparam [1:0] ST_RESUME = `HA_ST_RESUME;
    // float time is rounded up to whole clocks; the 4-bit counter keeps only its low 4 bits, so 16 wraps to 0
    localparam integer REL_CYC_I = `HA_REL_CYC;
    localparam [3:0]   REL_CYC   = REL_CYC_I[3:0];

    reg  [1:0] state;
    reg  [1:0] next_state;
    reg  [3:0] wait_cnt;
    reg  [3:0] next_wait_cnt;
    reg        drive;
    reg        next_drive;
    reg        in_reset;
    reg        next_lock_out_n;
    reg        next_hold_grant;
    reg        next_lock_oe;
    reg        next_lock_pullup;
    reg        next_core_cyc_go;
    wire       can_release;

    // a request is taken only at an unlocked boundary
    function release_ok;
        input req;
        input boundary;
        input locked;
        input lock_pin_n;
        begin
            release_ok = req & boundary & ~locked & lock_pin_n;
        end
    endfunction

    // state compare shared by the grant and cycle-start decode
    function in_state;
        input [1:0] cur;
        input [1:0] code;
        begin
            in_state = (cur == code);
        end
    endfunction

    // the float count ends on its last cycle
    function float_done;
        input [3:0] cnt;
        begin
            float_done = (cnt <= 4'h1);
        end
    endfunction

    // the registered lock level is also checked, so a lock seen late still blocks
    assign can_release = release_ok(hold_req, instr_end, lock_seq, lock_out_n);

    // atomic output follows the locked sequence only while we own the bus
    always @* begin
        next_lock_out_n = ~(lock_seq & drive);
    end

    // arbitration state sequence
    always @* begin
        next_state = state;
        case (state)
            ST_OWN: begin
                if (can_release) begin
                    next_state = ST_FLOAT;
                end
            end
            ST_FLOAT: begin
                // pins must be released before the grant is seen outside
                if (!hold_req) begin
                    next_state = ST_RESUME;
                end else if (float_done(wait_cnt)) begin
                    next_state = ST_GRANT;
                end
            end
            ST_GRANT: begin
                if (!hold_req) begin
                    next_state = ST_RESUME;
                end
            end
            ST_RESUME: begin
                next_state = ST_OWN;
            end
            default: begin
                next_state = ST_OWN;
            end
        endcase
    end

    // float time counted down before the grant goes out
    always @* begin
        next_wait_cnt = wait_cnt;
        case (state)
            ST_OWN: begin
                if (can_release) begin
                    next_wait_cnt = REL_CYC;
                end
            end
            ST_FLOAT: begin
                if (hold_req && !float_done(wait_cnt)) begin
                    next_wait_cnt = wait_cnt - 4'h1;
                end
            end
            default: begin
                next_wait_cnt = wait_cnt;
            end
        endcase
    end

    // pin drivers are off from the release edge until the resume state ends
    always @* begin
        next_drive = drive;
        case (state)
            ST_OWN: begin
                if (can_release) begin
                    next_drive = 1'b0;
                end
            end
            ST_RESUME: begin
                next_drive = 1'b1;
            end
            default: begin
                next_drive = drive;
            end
        endcase
    end

    always @* begin
        next_hold_grant  = in_state(next_state, ST_GRANT);
        // strong drive only from the second clock after reset, so the pull-up hands over cleanly
        next_lock_oe     = ~in_reset;
        next_lock_pullup = in_reset;
        // cycles start only once we own the bus and its drivers are already on
        next_core_cyc_go = core_cyc_req & next_drive & drive & in_state(next_state, ST_OWN);
    end

    // state machine registers
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ST_OWN;
            wait_cnt <= `HA_RST_WAIT;
            drive    <= `HA_RST_DRIVE;
        end else begin
            state    <= next_state;
            wait_cnt <= next_wait_cnt;
            drive    <= next_drive;
        end
    end

    // atomic pin: weak pull-up through reset, strong drive afterwards
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_reset    <= `HA_RST_IN_RESET;
            lock_out_n  <= `HA_RST_LOCK_N;
            lock_oe     <= `HA_RST_LOCK_OE;
            lock_pullup <= `HA_RST_PULLUP;
        end else begin
            in_reset    <= 1'b0;
            lock_out_n  <= next_lock_out_n;
            lock_oe     <= next_lock_oe;
            lock_pullup <= next_lock_pullup;
        end
    end

    // grant and cycle permission leave straight from flip-flops
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_grant  <= `HA_RST_GRANT;
            core_cyc_go <= `HA_RST_CYC_GO;
        end else begin
            hold_grant  <= next_hold_grant;
            core_cyc_go <= next_core_cyc_go;
        end
    end

    bus_drive_stage #(
        .DATA_W (DATA_W),
        .CTRL_W (CTRL_W)
    ) u_drive (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .drive    (next_drive),
        .data_in  (core_data),
        .data_wr  (core_data_wr),
        .ctrl_in  (core_ctrl),
        .data_out (bus_data_out),
        .data_oe  (bus_data_oe),
        .ctrl_out (bus_ctrl_out),
        .ctrl_oe  (bus_ctrl_oe)
    );
endmodule // local_bus_hold_arbitration
`default_nettype wire

// ---- tb/hold_master_model.sv ----
// external master that asks for the local bus
`default_nettype none
module hold_master_model (
    input  wire logic core_clk, // clock
    input  wire logic want,     // bus needed
    output var  logic hold_req  // request to the device
);
    timeunit 1ns;
    timeprecision 100ps;
    // level request kept while needed; the atomic pin is never driven from here
    always @(posedge core_clk) hold_req <= #1 want;
endmodule // hold_master_model
`default_nettype wire

// ---- tb/local_bus_hold_arbitration_asserts.sv ----
// checker on the hold arbitration ports
`default_nettype none
module hold_arb_chk (
    input wire logic core_clk,    // clock
    input wire logic rst_n,       // reset, active low
    input wire logic hold_req,    // external request
    input wire logic instr_end,   // instruction boundary
    input wire logic lock_seq,    // locked sequence
    input wire logic hold_grant,  // grant
    input wire logic lock_out_n,  // atomic output
    input wire logic lock_oe,     // atomic pin enable
    input wire logic lock_pullup, // atomic pin pull-up
    input wire logic core_cyc_go, // cycle permission
    input wire logic bus_data_oe, // data enable
    input wire logic bus_ctrl_oe  // control enable
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_grant_floats: assert property (hold_grant |-> !bus_data_oe && !bus_ctrl_oe)
        else $error("bus driven while granted");
    a_grant_cause: assert property ($rose(hold_grant) |-> $past(hold_req))
        else $error("grant without request");
    a_take_delay: assert property (hold_req && instr_end && !lock_seq && lock_out_n && bus_ctrl_oe
        |=> !bus_ctrl_oe ##1 (hold_grant || !$past(hold_req))) else $error("release late");
    a_release_point: assert property ($fell(bus_ctrl_oe) |-> $past(instr_end) && !$past(lock_seq))
        else $error("release off boundary");
    a_lock_idle: assert property (!lock_seq |=> lock_out_n) else $error("lock low unasked");
    a_lock_blocks: assert property (!lock_out_n |-> !hold_grant) else $error("grant in lock");
    a_pull_only: assert property (lock_pullup |-> !lock_oe) else $error("pull-up and drive");
    a_grant_end: assert property (hold_grant && !hold_req |=> !hold_grant) else $error("grant held");
    a_resume_order: assert property ($fell(hold_grant) |-> (!core_cyc_go && !bus_ctrl_oe)
        ##1 (!core_cyc_go && bus_ctrl_oe)) else $error("resume order");
    c_grant: cover property ($rose(hold_grant));
    c_locked_req: cover property (!lock_out_n && hold_req);
    c_resume: cover property ($fell(hold_grant));
    c_abort: cover property ($fell(bus_ctrl_oe) ##1 !hold_req ##1 !hold_grant);
endmodule // hold_arb_chk
bind local_bus_hold_arbitration hold_arb_chk u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .hold_req(hold_req), .instr_end(instr_end), .lock_seq(lock_seq), .hold_grant(hold_grant),
    .lock_out_n(lock_out_n), .lock_oe(lock_oe), .lock_pullup(lock_pullup),
    .core_cyc_go(core_cyc_go), .bus_data_oe(bus_data_oe), .bus_ctrl_oe(bus_ctrl_oe));
`default_nettype wire

// ---- tb/test_local_bus_hold_arbitration.sv ----
// bench for the hold arbitration block
`default_nettype none
module test_local_bus_hold_arbitration;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 0, rst_n = 0, want = 0, instr_end = 0, lock_seq = 0, hold_req;
    logic hold_grant, lock_out_n, lock_oe, lock_pullup, core_cyc_go, bus_data_oe, bus_ctrl_oe;
    logic [15:0] bus_data_out;
    logic [7:0]  bus_ctrl_out;
    int   fail_count = 0, samples_checked = 0;
    hold_master_model u_mst (.core_clk(core_clk), .want(want), .hold_req(hold_req));
    local_bus_hold_arbitration uut (.core_clk(core_clk), .rst_n(rst_n), .hold_req(hold_req),
        .instr_end(instr_end), .lock_seq(lock_seq), .core_cyc_req(1'b1), .core_data(16'h5a5a),
        .core_data_wr(1'b1), .core_ctrl(8'h3c), .hold_grant(hold_grant), .lock_out_n(lock_out_n),
        .lock_oe(lock_oe), .lock_pullup(lock_pullup), .core_cyc_go(core_cyc_go),
        .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .bus_ctrl_out(bus_ctrl_out),
        .bus_ctrl_oe(bus_ctrl_oe));
    initial forever #5 core_clk = ~core_clk;
    task chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // bounded wait, a hang ends the run as a mismatch
    task wait_grant(input logic e);
        for (int i = 0; i < 20 && hold_grant !== e; i++) step(1);
        if (hold_grant !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, hold_grant, e);
            finish_test;
        end
    endtask
    task t_grant;
        want = 1;
        step(6);
        chk(hold_grant, 0);
        instr_end = 1;
        wait_grant(1);
        chk(bus_ctrl_oe, 0);
        chk(bus_data_oe, 0);
        want = 0;
        wait_grant(0);
        chk(bus_ctrl_oe, 0);
        step(1);
        chk(bus_ctrl_oe, 1);
        chk(core_cyc_go, 0);
        chk(bus_ctrl_out, 16'h003c);
        chk(bus_data_out, 16'h5a5a);
        step(1);
        chk(core_cyc_go, 1);
    endtask
    // request dropped while the pins float: no grant, drivers come back
    task t_abort;
        step(2);
        want = 1;
        step(1);
        want = 0;
        step(1);
        chk(bus_ctrl_oe, 0);
        step(1);
        chk(hold_grant, 0);
        step(1);
        chk(bus_ctrl_oe, 1);
        chk(hold_grant, 0);
    endtask
    task t_lock;
        lock_seq = 1;
        want = 1;
        step(3);
        chk(lock_out_n, 0);
        step(5);
        chk(hold_grant, 0);
        lock_seq = 0;
        step(1);
        chk(bus_ctrl_oe, 1);
        wait_grant(1);
        chk(lock_out_n, 1);
        want = 0;
        wait_grant(0);
    endtask
    initial begin
        step(1);
        chk(lock_pullup, 1);
        chk(lock_oe, 0);
        chk(hold_grant, 0);
        step(4);
        rst_n = 1;
        step(1);
        chk(lock_oe, 0);
        step(1);
        chk(lock_oe, 1);
        chk(lock_pullup, 0);
        t_grant;
        t_lock;
        t_abort;
        finish_test;
    end
endmodule // test_local_bus_hold_arbitration
`default_nettype wire
